// >>> hdl/sigm_pkg.sv
// Constants, register map and state types for the signal measurement timer control block.
// Assumes a single clk_sys domain and a 32-bit AXI4-Lite register port.
package sigm_pkg;

	localparam int ADDR_W = 8;

	// Byte addresses of the registers.
	localparam logic [7:0] OFF_CONTROL_0 = 8'h00;
	localparam logic [7:0] OFF_CLOCK_SELECT = 8'h04;
	localparam logic [7:0] OFF_COUNT_LOW = 8'h08;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'h0c;
	localparam logic [7:0] OFF_COUNT_UPPER = 8'h10;
	localparam logic [7:0] OFF_PERIOD_LOW = 8'h14;
	localparam logic [7:0] OFF_PERIOD_HIGH = 8'h18;
	localparam logic [7:0] OFF_PERIOD_UPPER = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;

	// Fields of timer_control_0.
	localparam int BIT_ENABLE = 7;
	localparam int BIT_HALT_ON_MATCH = 5;
	localparam int BIT_WINDOW_POLARITY = 4;
	localparam int BIT_SIGNAL_POLARITY = 3;
	localparam int BIT_CLOCK_EDGE_POLARITY = 2;
	localparam int BIT_PRESCALE_HI = 1;
	localparam int BIT_PRESCALE_LO = 0;
	localparam logic [7:0] CONTROL_0_MASK = 8'hbf;

	// Clock source codes.
	localparam logic [2:0] CSRC_INSTRUCTION = 3'h0;
	localparam logic [2:0] CSRC_SYSTEM = 3'h1;
	localparam logic [2:0] CSRC_HIGH_INTERNAL = 3'h2;
	localparam logic [2:0] CSRC_LOW_INTERNAL = 3'h3;
	localparam logic [2:0] CSRC_MEDIUM_INTERNAL = 3'h4;
	localparam logic [2:0] CSRC_MEDIUM_DIV16 = 3'h5;
	localparam logic [2:0] CSRC_SECONDARY = 3'h6;
	localparam logic [2:0] CSRC_RESERVED = 3'h7;
	localparam int NUM_SOURCES = 7;

	// Reset values, and the value the count reloads to on a match.
	localparam logic [7:0] RST_CONTROL_0 = 8'h00;
	localparam logic [2:0] RST_CLOCK_SELECT = 3'h0;
	localparam logic [23:0] RST_COUNT = 24'h000000;
	localparam logic [23:0] RST_PERIOD = 24'hffffff;
	localparam logic [23:0] COUNT_RELOAD = 24'h000000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} sigm_state_t;

	typedef struct packed {
		logic [7:0] control_0;
		logic [2:0] clock_select;
		logic [23:0] count;
		logic [23:0] period;
		sigm_state_t state;
		logic src_prev;
		logic [2:0] prescale_count;
		logic match_pulse;
		logic win_prev;
		logic sig_prev;
		logic win_act;
		logic sig_act;
		logic win_edge;
		logic sig_edge;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sigm_regs_t;

endpackage

// >>> hdl/sigm_timer_ctrl.sv
// Control and 24-bit counter of the signal measurement timer with its AXI4-Lite register slave.
// Assumes all inputs, clock sources included, are synchronous to clk_sys; reset is nrst.
// How it works
// RL1: Clearing enable stops the timer, resets internal state, drops clock requests.
// RL2: Clearing enable leaves every software-visible register unchanged; here the status running and active bits clear.
// RL3: With halt set, a match holds the counter at period and pulses match.
// RL4: With halt clear, a match reloads all 24 bits to zero and pulses match.
// RL5: Window polarity bit picks active-low/falling when set, else active-high/rising.
// RL6: Signal polarity bit picks active-low/falling when set, else active-high/rising.
// RL7: Clock polarity bit makes counting use falling edges when set, rising when clear.
// RL8: Two-bit prescale divides counting edges by one, two, four or eight.
// RL9: Three-bit select picks one of seven clock sources; code seven is reserved.
// RL10: Counter is three software read-write bytes, all zero after any reset.
// RL11: While enabled the counter advances per prescaled edge; disabled it holds.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module sigm_timer_ctrl (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [6:0] clock_sources,
	input wire logic window_input,
	input wire logic measured_input,
	output logic [6:0] clock_request,
	output logic timer_running,
	output logic [23:0] counter_value,
	output logic period_match,
	output logic window_active,
	output logic signal_active,
	output logic window_edge,
	output logic signal_edge
);

	localparam sigm_pkg::sigm_regs_t REGS_RESET = '{
		control_0: sigm_pkg::RST_CONTROL_0,
		clock_select: sigm_pkg::RST_CLOCK_SELECT,
		count: sigm_pkg::RST_COUNT,
		period: sigm_pkg::RST_PERIOD,
		state: sigm_pkg::ST_IDLE,
		src_prev: 1'b0,
		prescale_count: 3'h0,
		match_pulse: 1'b0,
		win_prev: 1'b0,
		sig_prev: 1'b0,
		win_act: 1'b0,
		sig_act: 1'b0,
		win_edge: 1'b0,
		sig_edge: 1'b0,
		aw_held: 1'b0,
		aw_addr: 8'h00,
		w_held: 1'b0,
		w_data: 8'h00,
		w_lane0: 1'b0,
		bvalid: 1'b0,
		bresp: sigm_pkg::RESP_OKAY,
		rvalid: 1'b0,
		rdata: 32'h00000000,
		rresp: sigm_pkg::RESP_OKAY
	};

	sigm_pkg::sigm_regs_t regs_reg;
	sigm_pkg::sigm_regs_t regs_next;

	// Returns high when the byte address names a register of this block.
	function automatic logic addr_mapped(input logic [7:0] addr);
		case (addr)
			sigm_pkg::OFF_CONTROL_0,
			sigm_pkg::OFF_CLOCK_SELECT,
			sigm_pkg::OFF_COUNT_LOW,
			sigm_pkg::OFF_COUNT_HIGH,
			sigm_pkg::OFF_COUNT_UPPER,
			sigm_pkg::OFF_PERIOD_LOW,
			sigm_pkg::OFF_PERIOD_HIGH,
			sigm_pkg::OFF_PERIOD_UPPER,
			sigm_pkg::OFF_STATUS: begin
				addr_mapped = 1'b1;
			end
			default: begin
				addr_mapped = 1'b0;
			end
		endcase
	endfunction

	// Mask of prescaler bits that must all be set before a counting tick.
	function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
		case (sel)
			2'h0: prescale_mask = 3'h0;
			2'h1: prescale_mask = 3'h1;
			2'h2: prescale_mask = 3'h3;
			default: prescale_mask = 3'h7;
		endcase
	endfunction

	logic enabled;
	logic halt_on_match;
	logic window_polarity;
	logic signal_polarity;
	logic clock_edge_polarity;
	logic [1:0] prescale_select;
	logic source_valid;
	logic source_level;
	logic source_edge;
	logic tick;
	logic win_level;
	logic sig_level;
	logic do_write;
	logic wr_lane;
	logic [7:0] wr_addr;
	logic [7:0] wr_byte;
	logic count_written;

	assign enabled = regs_reg.control_0[sigm_pkg::BIT_ENABLE];
	assign halt_on_match = regs_reg.control_0[sigm_pkg::BIT_HALT_ON_MATCH];
	assign window_polarity = regs_reg.control_0[sigm_pkg::BIT_WINDOW_POLARITY];
	assign signal_polarity = regs_reg.control_0[sigm_pkg::BIT_SIGNAL_POLARITY];
	assign clock_edge_polarity = regs_reg.control_0[sigm_pkg::BIT_CLOCK_EDGE_POLARITY];
	assign prescale_select = regs_reg.control_0[sigm_pkg::BIT_PRESCALE_HI:sigm_pkg::BIT_PRESCALE_LO];

	// The reserved select code picks no source, so the counter never ticks on it.
	assign source_valid = (regs_reg.clock_select != sigm_pkg::CSRC_RESERVED); // see RL9
	assign source_level = source_valid ? clock_sources[regs_reg.clock_select] : 1'b0; // see RL9

	// Polarity correction turns an active-low input into an active-high level.
	assign win_level = window_input ^ window_polarity; // see RL5
	assign sig_level = measured_input ^ signal_polarity; // see RL6

	assign do_write = regs_reg.aw_held && regs_reg.w_held && !regs_reg.bvalid;
	assign wr_addr = regs_reg.aw_addr;
	assign wr_byte = regs_reg.w_data;
	assign wr_lane = regs_reg.w_lane0;
	assign count_written = do_write && wr_lane &&
		(wr_addr == sigm_pkg::OFF_COUNT_LOW || wr_addr == sigm_pkg::OFF_COUNT_HIGH ||
		wr_addr == sigm_pkg::OFF_COUNT_UPPER);

	always_comb begin
		regs_next = regs_reg;
		regs_next.match_pulse = 1'b0;
		regs_next.win_edge = 1'b0;
		regs_next.sig_edge = 1'b0;
		source_edge = 1'b0;
		tick = 1'b0;

		if (!enabled) begin
			// Only internal state is cleared, which the status bits show; the other software-visible registers keep their values.
			regs_next.state = sigm_pkg::ST_IDLE; // see RL1, RL2
			regs_next.prescale_count = 3'h0; // see RL1
			regs_next.win_act = 1'b0; // see RL1
			regs_next.sig_act = 1'b0; // see RL1
			// Tracking the levels while idle keeps enabling from faking an edge.
			regs_next.src_prev = source_level;
			regs_next.win_prev = win_level;
			regs_next.sig_prev = sig_level;
		end else begin
			unique case (regs_reg.state)
				sigm_pkg::ST_IDLE: begin
					regs_next.state = sigm_pkg::ST_RUN;
					regs_next.src_prev = source_level;
					regs_next.win_prev = win_level;
					regs_next.sig_prev = sig_level;
				end
				sigm_pkg::ST_RUN: begin
					regs_next.src_prev = source_level;
					if (clock_edge_polarity) begin
						source_edge = regs_reg.src_prev && !source_level; // see RL7
					end else begin
						source_edge = !regs_reg.src_prev && source_level; // see RL7
					end
					if (source_edge) begin
						if ((regs_reg.prescale_count & prescale_mask(prescale_select)) ==
							prescale_mask(prescale_select)) begin
							tick = 1'b1; // see RL8
							regs_next.prescale_count = 3'h0;
						end else begin
							regs_next.prescale_count = regs_reg.prescale_count + 3'h1; // see RL8
						end
					end
					regs_next.win_prev = win_level;
					regs_next.sig_prev = sig_level;
					regs_next.win_act = win_level; // see RL5
					regs_next.sig_act = sig_level; // see RL6
					regs_next.win_edge = win_level && !regs_reg.win_prev; // see RL5
					regs_next.sig_edge = sig_level && !regs_reg.sig_prev; // see RL6
				end
			endcase
		end

		if (tick) begin
			if (regs_reg.count == regs_reg.period) begin
				regs_next.match_pulse = 1'b1; // see RL3, RL4
				if (halt_on_match) begin
					regs_next.count = regs_reg.period; // see RL3
				end else begin
					regs_next.count = sigm_pkg::COUNT_RELOAD; // see RL4
				end
			end else begin
				regs_next.count = regs_reg.count + 24'h000001; // see RL11
			end
		end

		// Write address and write data are taken in either order.
		if (s_axi_awvalid && !regs_reg.aw_held && !regs_reg.bvalid) begin
			regs_next.aw_held = 1'b1;
			regs_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !regs_reg.w_held && !regs_reg.bvalid) begin
			regs_next.w_held = 1'b1;
			regs_next.w_data = s_axi_wdata[7:0];
			regs_next.w_lane0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			regs_next.aw_held = 1'b0;
			regs_next.w_held = 1'b0;
			regs_next.bvalid = 1'b1;
			regs_next.bresp = addr_mapped(wr_addr) ? sigm_pkg::RESP_OKAY : sigm_pkg::RESP_SLVERR;
			if (wr_lane) begin
				// A software write of a counter byte wins over a tick in the same cycle.
				unique case (wr_addr)
					sigm_pkg::OFF_CONTROL_0: begin
						regs_next.control_0 = wr_byte & sigm_pkg::CONTROL_0_MASK;
					end
					sigm_pkg::OFF_CLOCK_SELECT: begin
						regs_next.clock_select = wr_byte[2:0]; // see RL9
					end
					sigm_pkg::OFF_COUNT_LOW: begin
						regs_next.count = {regs_reg.count[23:8], wr_byte}; // see RL10
					end
					sigm_pkg::OFF_COUNT_HIGH: begin
						regs_next.count = {regs_reg.count[23:16], wr_byte, regs_reg.count[7:0]}; // see RL10
					end
					sigm_pkg::OFF_COUNT_UPPER: begin
						regs_next.count = {wr_byte, regs_reg.count[15:0]}; // see RL10
					end
					sigm_pkg::OFF_PERIOD_LOW: begin
						regs_next.period = {regs_reg.period[23:8], wr_byte};
					end
					sigm_pkg::OFF_PERIOD_HIGH: begin
						regs_next.period = {regs_reg.period[23:16], wr_byte, regs_reg.period[7:0]};
					end
					sigm_pkg::OFF_PERIOD_UPPER: begin
						regs_next.period = {wr_byte, regs_reg.period[15:0]};
					end
					default: begin
					end
				endcase
			end
		end
		if (regs_reg.bvalid && s_axi_bready) begin
			regs_next.bvalid = 1'b0;
		end

		if (s_axi_arvalid && !regs_reg.rvalid) begin
			regs_next.rvalid = 1'b1;
			regs_next.rresp = addr_mapped(s_axi_araddr) ? sigm_pkg::RESP_OKAY : sigm_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				sigm_pkg::OFF_CONTROL_0: begin
					regs_next.rdata = {24'h000000, regs_reg.control_0};
				end
				sigm_pkg::OFF_CLOCK_SELECT: begin
					regs_next.rdata = {29'h00000000, regs_reg.clock_select};
				end
				sigm_pkg::OFF_COUNT_LOW: begin
					regs_next.rdata = {24'h000000, regs_reg.count[7:0]}; // see RL10
				end
				sigm_pkg::OFF_COUNT_HIGH: begin
					regs_next.rdata = {24'h000000, regs_reg.count[15:8]}; // see RL10
				end
				sigm_pkg::OFF_COUNT_UPPER: begin
					regs_next.rdata = {24'h000000, regs_reg.count[23:16]}; // see RL10
				end
				sigm_pkg::OFF_PERIOD_LOW: begin
					regs_next.rdata = {24'h000000, regs_reg.period[7:0]};
				end
				sigm_pkg::OFF_PERIOD_HIGH: begin
					regs_next.rdata = {24'h000000, regs_reg.period[15:8]};
				end
				sigm_pkg::OFF_PERIOD_UPPER: begin
					regs_next.rdata = {24'h000000, regs_reg.period[23:16]};
				end
				sigm_pkg::OFF_STATUS: begin
					regs_next.rdata = {28'h0000000, regs_reg.sig_act, regs_reg.win_act,
						(regs_reg.count == regs_reg.period), regs_reg.state == sigm_pkg::ST_RUN};
				end
				default: begin
					regs_next.rdata = 32'h00000000;
				end
			endcase
		end else if (regs_reg.rvalid && s_axi_rready) begin
			regs_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			regs_reg <= REGS_RESET; // see RL10
		end else begin
			regs_reg <= regs_next;
		end
	end

	// Only the selected source is requested, and only while enabled.
	generate
		for (genvar i = 0; i < sigm_pkg::NUM_SOURCES; i++) begin : g_req
			assign clock_request[i] = enabled && (regs_reg.clock_select == 3'(i)); // see RL1, RL9
		end
	endgenerate

	assign s_axi_awready = !regs_reg.aw_held && !regs_reg.bvalid;
	assign s_axi_wready = !regs_reg.w_held && !regs_reg.bvalid;
	assign s_axi_bvalid = regs_reg.bvalid;
	assign s_axi_bresp = regs_reg.bresp;
	assign s_axi_arready = !regs_reg.rvalid;
	assign s_axi_rvalid = regs_reg.rvalid;
	assign s_axi_rdata = regs_reg.rdata;
	assign s_axi_rresp = regs_reg.rresp;
	assign timer_running = (regs_reg.state == sigm_pkg::ST_RUN);
	assign counter_value = regs_reg.count;
	assign period_match = regs_reg.match_pulse;
	assign window_active = regs_reg.win_act;
	assign signal_active = regs_reg.sig_act;
	assign window_edge = regs_reg.win_edge;
	assign signal_edge = regs_reg.sig_edge;

endmodule

// >>> verif/sigm_assertions.sv
// Port checks for sigm_timer_ctrl, bound into every instance.
// Assumes one clk_sys domain with synchronous active-low nrst.
`timescale 1ns/1ps
module sigm_assertions (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [6:0] clock_request,
	input wire logic timer_running,
	input wire logic [23:0] counter_value,
	input wire logic period_match,
	input wire logic signal_edge
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready during bvalid");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready during rvalid");
	req_drop_a: assert property ($fell(timer_running) |-> clock_request == 7'h00)
		else $error("request kept");
	req_hot_a: assert property ($onehot0(clock_request))
		else $error("request not one-hot");
	// A landing software write shows as a rising bvalid and may move the count freely.
	count_step_a: assert property (
		timer_running && $past(timer_running) && $changed(counter_value) &&
		!$rose(s_axi_bvalid) |->
		counter_value == $past(counter_value) + 24'h1 || counter_value == 24'h0)
		else $error("bad count step");
	match_run_a: assert property (period_match |-> $past(timer_running))
		else $error("match while idle");
	match_pulse_a: assert property (period_match |=> !period_match)
		else $error("match too long");
	edge_pulse_a: assert property (signal_edge |=> !signal_edge)
		else $error("edge too long");
	reset_zero_a: assert property (disable iff (1'b0) !nrst |=> counter_value == 24'h0 && !timer_running)
		else $error("no reset clear");
endmodule

bind sigm_timer_ctrl sigm_assertions sigm_chk (.clk_sys(clk_sys), .nrst(nrst),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.clock_request(clock_request), .timer_running(timer_running),
	.counter_value(counter_value), .period_match(period_match), .signal_edge(signal_edge));

// >>> verif/sigm_far_side.sv
// Far-side model: clock sources and the window and measured levels.
// Assumes bench commands change just after rising clk_sys edges.
`timescale 1ns/1ps
module sigm_far_side (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic run,
	input wire logic [6:0] mask,
	input wire logic win_lvl,
	input wire logic sig_lvl,
	output logic [6:0] clock_sources,
	output logic window_input,
	output logic measured_input
);
	logic phase = 1'b0;
	// Masked sources toggle every second cycle while run is high and stand still otherwise.
	always @(posedge clk_sys) begin
		phase <= nrst && run && !phase;
		if (!nrst) begin
			clock_sources <= 7'h00;
		end else if (run && phase) begin
			clock_sources <= clock_sources ^ mask;
		end
		window_input <= win_lvl;
		measured_input <= sig_lvl;
	end
endmodule

// >>> verif/test_sigm_timer_ctrl.sv
// Self-checking bench for sigm_timer_ctrl with the far-side model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module test_sigm_timer_ctrl;
	logic clk_sys = 1'b0, nrst = 1'b0, run = 1'b0, win_lvl = 1'b0, sig_lvl = 1'b0;
	logic [6:0] mask = 7'h01;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd, rq;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic awr, wr, bv, arr, rv, tr, pm, wa, sa, we, se;
	logic [1:0] bre, rre, rs;
	logic [6:0] cs, creq;
	logic [23:0] counter_value;
	logic win_in, sig_in;
	int miscompares = 0, samples_checked = 0;
	int n_pm = 0, n_we = 0, n_se = 0;
	// Counts one-cycle pulses at the falling edge, where they are settled.
	always @(negedge clk_sys) begin
		n_pm <= n_pm + int'(pm);
		n_we <= n_we + int'(we);
		n_se <= n_se + int'(se);
	end
	always #10 clk_sys = ~clk_sys;
	sigm_timer_ctrl DUT (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bre),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .clock_sources(cs), .window_input(win_in),
		.measured_input(sig_in), .clock_request(creq), .timer_running(tr),
		.counter_value(counter_value), .period_match(pm), .window_active(wa),
		.signal_active(sa), .window_edge(we), .signal_edge(se));
	sigm_far_side peer (.clk_sys(clk_sys), .nrst(nrst), .run(run), .mask(mask),
		.win_lvl(win_lvl), .sig_lvl(sig_lvl), .clock_sources(cs),
		.window_input(win_in), .measured_input(sig_in));
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One AXI4-Lite write or read; ready and valid are sampled mid-cycle, before the edge.
	// It starts one edge late, so a strobe just lowered is never raised in the same step.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, dn;
		@(posedge clk_sys);
		awa <= a;
		ara <= a;
		wd <= {24'h0, d};
		awv <= w;
		wv <= w;
		br <= w;
		arv <= !w;
		rr <= !w;
		for (int n = 0; n < 40; n++) begin
			@(negedge clk_sys);
			ta = awv && awr || arv && arr;
			tw = wv && wr;
			dn = bv && br || rv && rr;
			rq = rd;
			rs = w ? bre : rre;
			@(posedge clk_sys);
			if (ta) begin
				awv <= 1'b0;
				arv <= 1'b0;
			end
			if (tw) begin
				wv <= 1'b0;
			end
			if (dn) begin
				br <= 1'b0;
				rr <= 1'b0;
				return;
			end
		end
		miscompares++;
		$display("[FAIL] %0t bus timeout", $time);
		give_verdict();
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(rq, {24'h0, e});
	endtask
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
	endtask
	// Clears the low count byte, runs t source toggles enabled, then disables and reads back.
	task automatic meas(input logic [7:0] ctl, input int t, input logic [23:0] e);
		xfer(1'b1, 8'h08, 8'h00);
		xfer(1'b1, 8'h00, ctl | 8'h80);
		run <= 1'b1;
		repeat (2 * t) @(posedge clk_sys);
		run <= 1'b0;
		repeat (6) @(posedge clk_sys);
		xfer(1'b1, 8'h00, ctl);
		chk({8'h0, counter_value}, {8'h0, e});
		rchk(8'h08, e[7:0]);
		rchk(8'h00, ctl);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			rchk(8'(4 * i), 8'h00);
		end
		xfer(1'b0, 8'h24, 8'h00);
		chk({30'h0, rs}, {30'h0, sigm_pkg::RESP_SLVERR});
		xfer(1'b1, 8'h24, 8'h5a);
		chk({30'h0, rs}, {30'h0, sigm_pkg::RESP_SLVERR});
		$display("test reset done");
	endtask
	task automatic t_bytes();
		xfer(1'b1, 8'h08, 8'h12);
		xfer(1'b1, 8'h0c, 8'h34);
		xfer(1'b1, 8'h10, 8'h56);
		rchk(8'h0c, 8'h34);
		chk({8'h0, counter_value}, 32'h00563412);
		do_reset();
		chk({8'h0, counter_value}, 32'h0);
		rchk(8'h10, 8'h00);
		$display("test bytes done");
	endtask
	task automatic t_prescale();
		mask <= 7'h01;
		for (int c = 0; c < 2; c++) begin
			for (int p = 0; p < 4; p++) begin
				meas(8'(c * 4 + p), 32, 24'(16 >> p));
			end
		end
		$display("test prescale done");
	endtask
	task automatic t_select();
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, 8'h04, 8'(c));
			rchk(8'h04, 8'(c));
			xfer(1'b1, 8'h00, 8'h80);
			@(negedge clk_sys);
			chk({25'h0, creq}, {25'h0, 7'(1 << c)});
			chk({31'h0, tr}, 32'h1);
			xfer(1'b1, 8'h00, 8'h00);
			@(negedge clk_sys);
			chk({25'h0, creq}, 32'h0);
			chk({31'h0, tr}, 32'h0);
			mask <= 7'(1 << c);
			meas(8'h00, 8, (c == 7) ? 24'h0 : 24'h4);
			mask <= ~7'(1 << c);
			meas(8'h00, 8, 24'h0);
		end
		xfer(1'b1, 8'h04, 8'h00);
		$display("test select done");
	endtask
	task automatic t_period();
		int m0;
		mask <= 7'h01;
		xfer(1'b1, 8'h14, 8'h05);
		xfer(1'b1, 8'h18, 8'h00);
		xfer(1'b1, 8'h1c, 8'h01);
		xfer(1'b1, 8'h10, 8'h01);
		m0 = n_pm;
		meas(8'h20, 20, 24'h010005);
		chk(32'(n_pm - m0), 32'h5);
		xfer(1'b1, 8'h10, 8'h01);
		m0 = n_pm;
		meas(8'h00, 16, 24'h000002);
		chk(32'(n_pm - m0), 32'h1);
		$display("test period done");
	endtask
	task automatic t_polar();
		int w0, s0;
		for (int p = 0; p < 4; p++) begin
			xfer(1'b1, 8'h00, 8'(8'h80 | p << 3));
			for (int l = 0; l < 3; l++) begin
				w0 = n_we;
				s0 = n_se;
				win_lvl <= l[0];
				sig_lvl <= l[0];
				repeat (4) @(posedge clk_sys);
				chk({31'h0, wa}, {31'h0, l[0] ^ p[1]});
				chk({31'h0, sa}, {31'h0, l[0] ^ p[0]});
				chk(32'(n_we - w0), {31'h0, (l == 1 && !p[1]) || (l == 2 && p[1])});
				chk(32'(n_se - s0), {31'h0, (l == 1 && !p[0]) || (l == 2 && p[0])});
			end
			xfer(1'b1, 8'h00, 8'h00);
			win_lvl <= 1'b0;
			sig_lvl <= 1'b0;
		end
		$display("test polarity done");
	endtask
	initial begin
		do_reset();
		t_reset();
		t_bytes();
		t_prescale();
		t_select();
		t_period();
		t_polar();
		give_verdict();
	end
endmodule
